/* hw/tcf_pkg.sv */
// constants shared by the capture/compare channel and its helpers
// assumes a 32-bit apb slave, register words at aligned byte offsets
package tcf_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_IRQ_EN = 8'h08;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
    localparam logic [7:0] OFF_COUNTER = 8'h10;
    localparam logic [7:0] OFF_GREG_A = 8'h14;
    localparam logic [7:0] OFF_GREG_B = 8'h18;
    localparam logic [7:0] OFF_GREG_C = 8'h1c;
    localparam logic [7:0] OFF_GREG_D = 8'h20;

    // control register fields
    localparam int CTRL_W = 11;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_CAP_LSB = 1;
    localparam int CTRL_BUF_C_BIT = 5;
    localparam int CTRL_BUF_D_BIT = 6;
    localparam int CTRL_FALL_BIT = 7;
    localparam int CTRL_DIV_LSB = 8;
    localparam int DIV_W = 3;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;

    // flag positions inside channel_status
    localparam int FLAG_A = 0;
    localparam int FLAG_B = 1;
    localparam int FLAG_C = 2;
    localparam int FLAG_D = 3;
    localparam int NUM_GREG = 4;
    localparam logic [3:0] FLAGS_ALL = 4'hf;
    localparam logic [3:0] FLAGS_AB = 4'h3;

    // status bits 7:6 always read one, bits 5:4 not kept here
    localparam logic [3:0] STATUS_HI_FIXED = 4'hc;
    localparam logic [3:0] FLAG_RESET = 4'h0;
    localparam logic [3:0] IRQ_EN_RESET = 4'h0;

    localparam logic [15:0] COUNTER_RESET = 16'h0000;
    localparam logic [15:0] GREG_RESET = 16'hffff;
    localparam logic [7:0] DIV_CNT_RESET = 8'h00;

    // one-hot word select from a byte address
    function automatic logic [8:0] tcf_word_sel(input logic [7:0] addr);
        logic [8:0] sel;
        sel = 9'h000;
        sel[0] = (addr == OFF_CTRL);
        sel[1] = (addr == OFF_STATUS);
        sel[2] = (addr == OFF_IRQ_EN);
        sel[3] = (addr == OFF_IRQ_STAT);
        sel[4] = (addr == OFF_COUNTER);
        sel[5] = (addr == OFF_GREG_A);
        sel[6] = (addr == OFF_GREG_B);
        sel[7] = (addr == OFF_GREG_C);
        sel[8] = (addr == OFF_GREG_D);
        return sel;
    endfunction

endpackage

/* hw/tcf_capture_sync.sv */
// three-stage synchroniser for capture pins with edge pulses
// assumes pins are asynchronous to ref_clk_in
`timescale 1ns/1ps

module tcf_capture_sync #(
    parameter int W = 4
) (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] rise_out,
    output logic [W-1:0] fall_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync2_q;
    logic [W-1:0] sync3_q;
    logic [W-1:0] level_q;
    logic [W-1:0] level_d;
    logic [W-1:0] agree;

    // a change counts only once stages two and three agree
    assign agree = ~(sync2_q ^ sync3_q);
    assign level_d = (agree & sync2_q) | (~agree & level_q);
    assign rise_out = level_d & ~level_q;
    assign fall_out = ~level_d & level_q;

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            level_q <= '0;
        end else begin
            meta_q <= pin_in;
            sync2_q <= meta_q;
            sync3_q <= sync2_q;
            level_q <= level_d;
        end
    end

endmodule

/* hw/tcf_channel.sv */
// one timer channel: counter, general registers, match/capture flags
// assumes an apb master on ref_clk_in and a transfer controller that
// pulses xfer_ack_in when it is activated by a flag's request
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps

// Contract
// RL1 - with C/D: flag D sets when the counter equals register D in compare.
// RL2 - channels with C/D: flag D sets when a capture loads register D.
// RL3 - channels without C/D: status bits 3 and 2 read zero, ignore writes.
// RL4 - channels with C/D: flag C (bit 2) sets on compare or capture of C.
// RL5 - flag B (bit 1) sets on compare equality or capture of register B.
// RL6 - flag A (bit 0) sets on compare equality or capture of register A.
// RL7 - flag clears only on read of one then write of zero; one ignored.
// RL8 - flag clears when its request starts the controller with select zero.
// RL9 - the channel has its own readable, writable 16-bit counter.
// RL10 - counter returns to zero on reset and during hardware standby.
// RL11 - software accesses the counter only as a full 16-bit word.
// RL12 - four general registers with C/D, two without; compare or capture.
// RL13 - with C/D, C may buffer A and D may buffer B.
// RL14 - software accesses general registers only as full 16-bit words.
// RL15 - a flag requests an interrupt only while its enable bit is one.
// RL16 - set and clear in the same cycle leave the flag set.
module tcf_channel #(
    parameter bit HAS_CD = 1'b1
) (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [tcf_pkg::NUM_GREG-1:0] capture_pin_in,
    input wire logic standby_in,
    input wire logic [tcf_pkg::NUM_GREG-1:0] xfer_ack_in,
    input wire logic [tcf_pkg::NUM_GREG-1:0] xfer_irq_select_bit_in,
    output logic [tcf_pkg::NUM_GREG-1:0] irq_match_out,
    output logic irq_out
);
    import tcf_pkg::*;

    localparam logic [3:0] FLAG_IMPL = HAS_CD ? FLAGS_ALL : FLAGS_AB;

    // register state
    logic [CTRL_W-1:0] ctrl_q;
    logic [CTRL_W-1:0] ctrl_d;
    logic [3:0] flag_q;
    logic [3:0] flag_d;
    logic [3:0] armed_q;
    logic [3:0] armed_d;
    logic [3:0] irq_en_q;
    logic [3:0] irq_en_d;
    logic [3:0] irq_stat_q;
    logic [3:0] irq_stat_d;
    logic [15:0] counter_q;
    logic [15:0] counter_d;
    logic [15:0] greg_q [NUM_GREG];
    logic [15:0] greg_d [NUM_GREG];
    logic [7:0] div_q;
    logic [7:0] div_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;

    // bus decode
    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic [8:0] sel;
    logic mapped;
    logic word_reg;
    logic bad_strb;
    logic wr_ok;
    logic wr_status;
    logic wr_irq_stat;
    logic rd_status;
    logic [3:0] sel_greg;

    assign setup = psel_in & ~penable_in;
    assign access = psel_in & penable_in;
    assign wr = access & pwrite_in;
    assign rd = access & ~pwrite_in;
    assign sel = tcf_word_sel(paddr_in);
    assign mapped = (|sel[6:0]) | (HAS_CD & (|sel[8:7]));
    assign sel_greg = HAS_CD ? sel[8:5] : {2'b00, sel[6:5]};
    // 16-bit registers refuse byte-lane writes
    assign word_reg = sel[4] | (|sel_greg);
    assign bad_strb = wr & word_reg & (pstrb_in[1:0] != 2'b11); // RL11 RL14
    assign wr_ok = wr & mapped & ~bad_strb;
    assign wr_status = wr_ok & sel[1];
    assign wr_irq_stat = wr_ok & sel[3];
    assign rd_status = rd & sel[1];

    // zero wait states: read data is latched in the setup cycle
    assign pready_out = 1'b1;
    assign pslverr_out = access & (~mapped | bad_strb);
    assign prdata_out = prdata_q;

    // control fields
    logic run;
    logic [3:0] cap_mode;
    logic buf_c;
    logic buf_d;
    logic cap_fall;
    logic [DIV_W-1:0] div_sel;

    assign run = ctrl_q[CTRL_RUN_BIT];
    assign cap_mode = ctrl_q[CTRL_CAP_LSB +: 4] & FLAG_IMPL;
    assign buf_c = HAS_CD & ctrl_q[CTRL_BUF_C_BIT]; // RL13
    assign buf_d = HAS_CD & ctrl_q[CTRL_BUF_D_BIT]; // RL13
    assign cap_fall = ctrl_q[CTRL_FALL_BIT];
    assign div_sel = ctrl_q[CTRL_DIV_LSB +: DIV_W];

    // prescaler: count tick every 2^div_sel cycles while running
    logic [7:0] div_mask;
    logic tick;

    assign div_mask = 8'(8'hff >> (4'd8 - {1'b0, div_sel}));
    assign tick = run & ~standby_in & ((div_q & div_mask) == div_mask);
    assign div_d = (run & ~standby_in) ? 8'(div_q + 8'h01) : DIV_CNT_RESET;

    // capture inputs
    logic [3:0] pin_rise;
    logic [3:0] pin_fall;
    logic [3:0] cap_edge;

    tcf_capture_sync #(
        .W(NUM_GREG)
    ) u_cap_sync (
        .ref_clk_in(ref_clk_in),
        .arst_n_in(arst_n_in),
        .pin_in(capture_pin_in),
        .rise_out(pin_rise),
        .fall_out(pin_fall)
    );

    assign cap_edge = cap_fall ? pin_fall : pin_rise;

    // events
    logic [15:0] counter_inc;
    logic [3:0] cmp_ev;
    logic [3:0] cap_ev;
    logic [3:0] own_ev;
    logic [3:0] set_ev;

    assign counter_inc = 16'(counter_q + 16'h0001);

    // compare fires as the counter steps onto the register value
    genvar g;
    generate
        for (g = 0; g < NUM_GREG; g++) begin : g_ev
            assign cmp_ev[g] = tick & ~cap_mode[g] & ~standby_in
                & (counter_inc == greg_q[g]); // RL1 RL4 RL5 RL6
            assign cap_ev[g] = cap_mode[g] & cap_edge[g]; // RL2 RL4 RL5 RL6
        end
    endgenerate

    assign own_ev = (cmp_ev | cap_ev) & FLAG_IMPL;
    // a register used as a buffer raises no flag of its own
    assign set_ev = own_ev & {~buf_d, ~buf_c, 2'b11};

    // set joins after the clear, so a colliding event survives
    function automatic logic [3:0] tcf_sticky_next(input logic [3:0] cur,
            input logic [3:0] clr, input logic [3:0] set);
        return ((cur & ~clr) | set) & FLAG_IMPL;
    endfunction

    // counter
    always_comb begin
        counter_d = counter_q;
        if (standby_in) begin
            counter_d = COUNTER_RESET; // RL10
        end else if (wr_ok & sel[4]) begin
            counter_d = pwdata_in[15:0]; // RL9
        end else if (tick) begin
            counter_d = counter_inc; // RL9
        end
    end

    // general registers: hardware transfers win over software writes
    always_comb begin
        for (int i = 0; i < NUM_GREG; i++) begin
            greg_d[i] = greg_q[i];
            if (wr_ok & sel_greg[i]) begin
                greg_d[i] = pwdata_in[15:0]; // RL12
            end
        end
        for (int i = 0; i < NUM_GREG; i++) begin
            if (cap_ev[i] & FLAG_IMPL[i]) begin
                greg_d[i] = counter_q; // RL2 RL12
            end
        end
        // buffer pairs: A with C, B with D
        if (buf_c & cap_ev[FLAG_A]) begin
            greg_d[FLAG_C] = greg_q[FLAG_A]; // RL13
        end
        if (buf_d & cap_ev[FLAG_B]) begin
            greg_d[FLAG_D] = greg_q[FLAG_B]; // RL13
        end
        if (buf_c & cmp_ev[FLAG_A]) begin
            greg_d[FLAG_A] = greg_q[FLAG_C]; // RL13
        end
        if (buf_d & cmp_ev[FLAG_B]) begin
            greg_d[FLAG_B] = greg_q[FLAG_D]; // RL13
        end
    end

    // flags
    logic [3:0] clr_sw;
    logic [3:0] clr_xfer;

    // software clears a flag only with a zero in the first status write after reading it as one
    assign clr_sw = {4{wr_status}} & armed_q & ~pwdata_in[3:0]; // RL7
    assign clr_xfer = xfer_ack_in & ~xfer_irq_select_bit_in; // RL8
    assign flag_d = tcf_sticky_next(flag_q, clr_sw | clr_xfer,
        set_ev); // RL16 RL3

    always_comb begin
        armed_d = armed_q;
        if (rd_status) begin
            armed_d = prdata_q[3:0] & FLAG_IMPL;
        end else if (wr_status) begin
            armed_d = 4'h0;
        end
        // a flag taken by the controller must be read again
        armed_d = armed_d & ~clr_xfer;
    end

    // interrupt requests
    assign irq_match_out = flag_q & irq_en_q; // RL15
    assign irq_en_d = (wr_ok & sel[2]) ? (pwdata_in[3:0] & FLAG_IMPL)
        : irq_en_q;
    assign irq_stat_d = tcf_sticky_next(irq_stat_q,
        {4{wr_irq_stat}} & pwdata_in[3:0], set_ev); // RL16
    assign irq_out = |(irq_stat_q & irq_en_q); // RL15
    assign ctrl_d = (wr_ok & sel[0]) ? pwdata_in[CTRL_W-1:0] : ctrl_q;

    // read mux, sampled during setup
    logic [7:0] status_rd;

    assign status_rd = {STATUS_HI_FIXED, flag_q & FLAG_IMPL}; // RL3

    always_comb begin
        prdata_d = prdata_q;
        if (setup & ~pwrite_in) begin
            prdata_d = 32'h0000_0000;
            unique case (1'b1)
                sel[0]: prdata_d[CTRL_W-1:0] = ctrl_q;
                sel[1]: prdata_d[7:0] = status_rd;
                sel[2]: prdata_d[3:0] = irq_en_q;
                sel[3]: prdata_d[3:0] = irq_stat_q;
                sel[4]: prdata_d[15:0] = counter_q;
                sel_greg[0]: prdata_d[15:0] = greg_q[0];
                sel_greg[1]: prdata_d[15:0] = greg_q[1];
                sel_greg[2]: prdata_d[15:0] = greg_q[2];
                sel_greg[3]: prdata_d[15:0] = greg_q[3];
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctrl_q <= CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            flag_q <= FLAG_RESET;
        end else begin
            flag_q <= flag_d;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            armed_q <= FLAG_RESET;
        end else begin
            armed_q <= armed_d;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_en_q <= IRQ_EN_RESET;
        end else begin
            irq_en_q <= irq_en_d;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_stat_q <= FLAG_RESET;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            counter_q <= COUNTER_RESET; // RL10
        end else begin
            counter_q <= counter_d;
        end
    end

    // restarts with each run, so the first tick is a full period in
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            div_q <= DIV_CNT_RESET;
        end else begin
            div_q <= div_d;
        end
    end

    // holds between reads, so a late sampler still sees the word
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prdata_q <= 32'h0000_0000;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < NUM_GREG; i++) begin
                greg_q[i] <= GREG_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_GREG; i++) begin
                greg_q[i] <= greg_d[i];
            end
        end
    end

endmodule

/* verification/tcf_checker.sv */
// assertions on the ports of one capture/compare channel
// assumes apb read data is latched at the setup edge
`timescale 1ns/1ps

module tcf_checker
    import tcf_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic standby_in,
    input wire logic [3:0] xfer_ack_in,
    input wire logic [3:0] xfer_irq_select_bit_in,
    input wire logic [3:0] irq_match_out,
    input wire logic irq_out
);
    logic [3:0] en_q;
    logic rd;
    logic wr;
    assign rd = psel_in && penable_in && !pwrite_in;
    assign wr = psel_in && penable_in && pwrite_in;
    // shadow of the enable register, to judge the request outputs
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            en_q <= IRQ_EN_RESET;
        end else if (wr && paddr_in == OFF_IRQ_EN) begin
            en_q <= pwdata_in[3:0];
        end
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);

    chk_status_high: assert property (
        rd && paddr_in == OFF_STATUS |-> prdata_out[7:4] == STATUS_HI_FIXED)
        else $error("status high bits wrong");
    chk_counter_upper: assert property (
        rd && paddr_in == OFF_COUNTER |-> prdata_out[31:16] == 16'h0000)
        else $error("counter upper bits set");
    chk_greg_upper: assert property (
        rd && paddr_in >= OFF_GREG_A && paddr_in <= OFF_GREG_D
        |-> prdata_out[31:16] == 16'h0000)
        else $error("general reg upper bits set");
    chk_standby_zero: assert property (
        psel_in && !penable_in && !pwrite_in && paddr_in == OFF_COUNTER
        && standby_in && $past(standby_in) |=> prdata_out[15:0] == 16'h0000)
        else $error("counter not zero in standby");
    chk_match_gated: assert property (
        (irq_match_out & ~en_q) == 4'h0)
        else $error("request without enable");
    chk_irq_quiet: assert property (
        en_q == 4'h0 |-> !irq_out)
        else $error("interrupt while all masked");
    chk_status_view: assert property (
        rd && paddr_in == OFF_STATUS && $past(en_q) == FLAGS_ALL
        |-> prdata_out[3:0] == $past(irq_match_out))
        else $error("status flags disagree with requests");
    chk_flag_fall: assert property (
        |($past(irq_match_out) & ~irq_match_out) |-> $past(wr &&
        (paddr_in == OFF_STATUS || paddr_in == OFF_IRQ_EN))
        || $past(|(xfer_ack_in & ~xfer_irq_select_bit_in)))
        else $error("flag dropped without cause");

    cov_flags_seen: cover property (rd && paddr_in == OFF_STATUS
        && prdata_out[3:0] != 4'h0);
    cov_xfer_clear: cover property (|(xfer_ack_in & ~xfer_irq_select_bit_in));
    cov_standby_read: cover property (standby_in && rd);
endmodule

/* verification/tcf_xfer_model.sv */
// transfer controller model: one activation per new flag request
// assumes requests are levels; select bits held by the bench
`timescale 1ns/1ps

module tcf_xfer_model (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic [3:0] irq_match_in,
    input wire logic [3:0] arm_in,
    input wire logic [3:0] irq_select_bit_cfg_in,
    output logic [3:0] xfer_ack_out,
    output logic [3:0] xfer_irq_select_bit_out
);
    logic [3:0] seen_q;
    logic [3:0] req;
    assign req = irq_match_in & arm_in;
    assign xfer_irq_select_bit_out = irq_select_bit_cfg_in;
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            seen_q <= 4'h0;
            xfer_ack_out <= 4'h0;
        end else begin
            seen_q <= req;
            // edge only: a held request with select one must not retrigger
            xfer_ack_out <= req & ~seen_q;
        end
    end
endmodule

/* verification/tb.sv */
// self-checking bench for one channel with its C/D registers
// assumes a zero-wait apb slave and the transfer model beside it
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end

module tb;
    import tcf_pkg::*;
    logic ref_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, standby = 1'b0;
    logic perr, rerr, pready, irq;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic [3:0] cap = 4'h0, arm = 4'h0, dcfg = 4'h0, ack, irq_select_bit, irqm;
    int errors = 0;
    int checks = 0;

    initial begin
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end

    tcf_channel #(.HAS_CD(1'b1)) tcf_channel_inst (
        .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .pstrb_in(4'hf), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(perr), .capture_pin_in(cap),
        .standby_in(standby), .xfer_ack_in(ack), .xfer_irq_select_bit_in(irq_select_bit),
        .irq_match_out(irqm), .irq_out(irq));
    tcf_xfer_model tcf_xfer_model_inst (
        .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
        .irq_match_in(irqm), .arm_in(arm), .irq_select_bit_cfg_in(dcfg),
        .xfer_ack_out(ack), .xfer_irq_select_bit_out(irq_select_bit));

    // full-word strobes only; byte access to counter/regs is unsupported
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_in);
        pen <= 1'b1;
        do @(posedge ref_clk_in); while (pready !== 1'b1);
        rdata = prdata;
        rerr = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge ref_clk_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic expect_rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK($sformatf("reg %h", a), e, rdata)
    endtask
    task automatic wait_match(input logic [3:0] e);
        for (int n = 0; n < 200 && irqm !== e; n++) @(posedge ref_clk_in);
    endtask

    task automatic t_reset();
        expect_rd(OFF_STATUS, 32'h000000c0);
        expect_rd(OFF_COUNTER, 32'h0);
        expect_rd(OFF_GREG_D, {16'h0, GREG_RESET});
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped err", 1'b1, rerr)
        `CHK("irq", 1'b0, irq)
    endtask
    task automatic t_counter();
        wr(OFF_COUNTER, 32'h0000beef);
        expect_rd(OFF_COUNTER, 32'h0000beef);
        standby <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        expect_rd(OFF_COUNTER, 32'h0);
        standby <= 1'b0;
        @(posedge ref_clk_in);
    endtask
    task automatic t_compare();
        for (int i = 0; i < 4; i++) wr(OFF_GREG_A + 8'(4 * i), 32'(5 + 2 * i));
        wr(OFF_IRQ_EN, 32'hf);
        wr(OFF_COUNTER, 32'h0);
        wr(OFF_CTRL, 32'h1);
        wait_match(4'hf);
        wr(OFF_CTRL, 32'h0);
        expect_rd(OFF_STATUS, 32'hcf);
        `CHK("irq set", 1'b1, irq)
    endtask
    task automatic t_clear();
        wr(OFF_STATUS, 32'hff);
        expect_rd(OFF_STATUS, 32'hcf);
        wr(OFF_STATUS, 32'hce);
        wr(OFF_STATUS, 32'hc0);
        expect_rd(OFF_STATUS, 32'hce);
    endtask
    task automatic t_xfer();
        dcfg <= 4'h4;
        arm <= 4'h6;
        wait_match(4'hc);
        repeat (2) @(posedge ref_clk_in);
        arm <= 4'h0;
        expect_rd(OFF_STATUS, 32'hcc);
        wr(OFF_STATUS, 32'hc4);
        expect_rd(OFF_STATUS, 32'hc4);
    endtask
    task automatic t_mask();
        wr(OFF_IRQ_EN, 32'h0);
        `CHK("match off", 4'h0, irqm)
        `CHK("irq off", 1'b0, irq)
        wr(OFF_IRQ_EN, 32'h4);
        `CHK("match c", 4'h4, irqm)
        `CHK("irq on", 1'b1, irq)
        wr(OFF_IRQ_STAT, 32'hf);
        `CHK("irq cleared", 1'b0, irq)
    endtask
    task automatic t_capture();
        wr(OFF_COUNTER, 32'h42);
        wr(OFF_CTRL, 32'h12);
        wr(OFF_IRQ_EN, 32'hf);
        cap <= 4'h9;
        wait_match(4'hd);
        expect_rd(OFF_GREG_A, 32'h42);
        expect_rd(OFF_GREG_D, 32'h42);
        expect_rd(OFF_STATUS, 32'hcd);
    endtask
    task automatic t_collide();
        wr(OFF_COUNTER, 32'h77);
        wr(OFF_CTRL, 32'h82);
        cap <= 4'h8;
        repeat (2) @(posedge ref_clk_in);
        // falling capture of A lands on the access edge of this clear
        wr(OFF_STATUS, 32'hc8);
        expect_rd(OFF_STATUS, 32'hc9);
        expect_rd(OFF_GREG_A, 32'h77);
    endtask
    task automatic t_buffer();
        wr(OFF_STATUS, 32'hc0);
        wr(OFF_GREG_A, 32'h103);
        wr(OFF_GREG_C, 32'h104);
        wr(OFF_COUNTER, 32'h100);
        wr(OFF_CTRL, 32'h21);
        wait_match(4'h1);
        wr(OFF_CTRL, 32'h0);
        expect_rd(OFF_GREG_A, 32'h104);
        expect_rd(OFF_STATUS, 32'hc1);
        // divide by four: sixteen running cycles give four counts
        wr(OFF_COUNTER, 32'h0);
        wr(OFF_CTRL, 32'h201);
        repeat (13) @(posedge ref_clk_in);
        wr(OFF_CTRL, 32'h0);
        expect_rd(OFF_COUNTER, 32'h4);
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge ref_clk_in);
        arst_n_in <= 1'b1;
        @(posedge ref_clk_in);
        t_reset();
        t_counter();
        t_compare();
        t_clear();
        t_xfer();
        t_mask();
        t_capture();
        t_collide();
        t_buffer();
        summarize();
    end

    // the sequence needs well under a thousand cycles
    initial begin
        #20000;
        errors++;
        summarize();
    end
endmodule

bind tcf_channel tcf_checker tcf_checker_inst (
    .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .standby_in(standby_in),
    .xfer_ack_in(xfer_ack_in), .xfer_irq_select_bit_in(xfer_irq_select_bit_in),
    .irq_match_out(irq_match_out), .irq_out(irq_out));
